// file: hw/ssc_defines.vh
// Constants for the SRAM sleep control block.
// Assumes a single 25 MHz ref_clk; included by bare name.
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
`define SSC_CLK_PERIOD_NS     40
`define SSC_ENTRY_CYCLES      2'h2
`define SSC_RECOVERY_TIME_NS  20
// Recovery time rounded up to whole clock periods, counter width
`define SSC_RECOVERY_CYCLES   2'h1
`define SSC_CNT_W             2
`define SSC_ST_AWAKE          2'h0
`define SSC_ST_ENTER          2'h1
`define SSC_ST_SLEEP          2'h2
`define SSC_ST_RECOVER        2'h3
`define SSC_CMD_DESELECT      2'h0
`define SSC_CMD_READ          2'h1
`define SSC_CMD_WRITE         2'h2
`define SSC_CMD_NOP           2'h3
`define SSC_DATA_W            36
`define SSC_ADDR_W            4
`define SSC_DEPTH             16
`endif

// file: hw/ssc_counter.v
// Small down counter used to time sleep entry and recovery.
// Assumes load and load_value come from the controller on ref_clk.
`timescale 1ns/100ps
`include "ssc_defines.vh"
module ssc_counter (
  input  wire                  ref_clk,
  input  wire                  rstn,
  input  wire                  load,
  input  wire [`SSC_CNT_W-1:0] load_value,
  output wire                  done
);
  reg [`SSC_CNT_W-1:0] count;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= {`SSC_CNT_W{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (count != {`SSC_CNT_W{1'b0}}) begin
      count <= count - {{(`SSC_CNT_W-1){1'b0}}, 1'b1};
    end
  end
  assign done = (count == {{(`SSC_CNT_W-1){1'b0}}, 1'b1}) && !load;
endmodule

// file: hw/ssc_sleep_ctrl.v
// SRAM core with sleep request control, deselect and output float.
// Assumes controller pins are synchronous to ref_clk; sleep_request sampled.
// Behaviour
// - Undriven sleep request counts as low
// - Sleep entered four cycles after request rises
// - Array and state kept while asleep
// - Normal operation after recovery time elapses
// - Deselected while sleep request stays high
// - Asleep: inputs ignored, data outputs floated
// - Sleep request independent of command inputs
`timescale 1ns/100ps
`include "ssc_defines.vh"
module ssc_sleep_ctrl (
  input  wire                  ref_clk,
  input  wire                  rstn,
  input  wire                  sleep_request,
  input  wire                  sleep_request_driven,
  input  wire [1:0]            cmd,
  input  wire [`SSC_ADDR_W-1:0] addr,
  input  wire [`SSC_DATA_W-1:0] wr_data,
  output reg  [`SSC_DATA_W-1:0] rd_data,
  output reg                   rd_data_oe,
  output wire                  asleep,
  output wire                  recovering,
  output wire                  write_refused
);
  reg [1:0]             state;
  reg [1:0]             next_state;
  reg                   req_sample;
  reg [`SSC_DATA_W-1:0] mem [0:`SSC_DEPTH-1];
  wire                  req_eff;
  reg                   cnt_load;
  reg  [`SSC_CNT_W-1:0] cnt_value;
  wire                  cnt_done;
  reg                   st_asleep;
  reg                   st_recover;
  reg                   cmd_read;
  reg                   cmd_write;
  wire                  sleep_next;
  wire                  serve_read;
  wire                  active;
  wire                  do_read;
  wire                  do_write;

  // Undriven pin reads as low, like a pull-down
  assign req_eff = sleep_request & sleep_request_driven;

  // Sampled every edge, no reset dependence on commands
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_sample <= 1'b0;
    end else begin
      req_sample <= req_eff;
    end
  end

  // Counter load per state: entry on the first high sample, recovery
  // restarted by every low sample while asleep
  always @* begin
    cnt_load  = 1'b0;
    cnt_value = `SSC_RECOVERY_CYCLES;
    case (state)
      `SSC_ST_AWAKE: begin
        cnt_load  = req_sample;
        cnt_value = `SSC_ENTRY_CYCLES;
      end
      `SSC_ST_ENTER: begin
        // No reload, so entry runs out even if the request drops
        cnt_load  = 1'b0;
        cnt_value = `SSC_RECOVERY_CYCLES;
      end
      `SSC_ST_SLEEP: begin
        cnt_load  = !req_sample;
        cnt_value = `SSC_RECOVERY_CYCLES;
      end
      default: begin
        cnt_load  = 1'b0;
        cnt_value = `SSC_RECOVERY_CYCLES;
      end
    endcase
  end

  ssc_counter u_counter (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .load       (cnt_load),
    .load_value (cnt_value),
    .done       (cnt_done)
  );

  always @* begin
    next_state = state;
    case (state)
      `SSC_ST_AWAKE: begin
        if (req_sample) begin
          next_state = `SSC_ST_ENTER;
        end
      end
      `SSC_ST_ENTER: begin
        // Four cycles after the rise, even if the request dropped
        if (cnt_done) begin
          next_state = `SSC_ST_SLEEP;
        end
      end
      `SSC_ST_SLEEP: begin
        // Sleep lasts as long as the request is high
        if (!req_sample) begin
          next_state = `SSC_ST_RECOVER;
        end
      end
      `SSC_ST_RECOVER: begin
        // A new rise during recovery goes straight back to sleep
        if (req_sample) begin
          next_state = `SSC_ST_SLEEP;
        end else if (cnt_done) begin
          next_state = `SSC_ST_AWAKE;
        end
      end
      default: begin
        next_state = `SSC_ST_AWAKE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= `SSC_ST_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  // Flags decoded per state; only the sleep state deselects the core
  always @* begin
    st_asleep  = 1'b0;
    st_recover = 1'b0;
    case (state)
      `SSC_ST_AWAKE: begin
        st_asleep  = 1'b0;
        st_recover = 1'b0;
      end
      `SSC_ST_ENTER: begin
        // Entry window still serves commands; the controller drains first
        st_asleep  = 1'b0;
        st_recover = 1'b0;
      end
      `SSC_ST_SLEEP: begin
        // Deselected for as long as the request stays high
        st_asleep  = 1'b1;
        st_recover = 1'b0;
      end
      `SSC_ST_RECOVER: begin
        st_asleep  = 1'b0;
        st_recover = 1'b1;
      end
      default: begin
        st_asleep  = 1'b0;
        st_recover = 1'b0;
      end
    endcase
  end

  assign asleep     = st_asleep;
  assign recovering = st_recover;
  assign active     = !st_asleep;
  // Look-ahead so a read on the entry edge never drives the bus asleep
  assign sleep_next = (next_state == `SSC_ST_SLEEP);

  // Deselect and nop both leave the array and rd_data alone; rd_data_oe drops
  always @* begin
    cmd_read  = 1'b0;
    cmd_write = 1'b0;
    case (cmd)
      `SSC_CMD_READ: begin
        cmd_read = 1'b1;
      end
      `SSC_CMD_WRITE: begin
        cmd_write = 1'b1;
      end
      `SSC_CMD_DESELECT: begin
        cmd_read  = 1'b0;
        cmd_write = 1'b0;
      end
      default: begin
        cmd_read  = 1'b0;
        cmd_write = 1'b0;
      end
    endcase
  end

  // Writes in recovery are refused rather than risk corruption
  assign do_write      = active && !st_recover && cmd_write;
  assign do_read       = active && cmd_read;
  assign serve_read    = do_read && !sleep_next;
  assign write_refused = st_recover && cmd_write;

  // Array untouched while asleep; no reset so contents survive
  always @(posedge ref_clk) begin
    if (do_write) begin
      mem[addr] <= wr_data;
    end
  end

  // Outputs float and inputs ignored while asleep
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= serve_read;
    end
  end

  // Last word held while floated; saves toggling a bus nobody reads
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= {`SSC_DATA_W{1'b0}};
    end else if (serve_read) begin
      rd_data <= mem[addr];
    end
  end
endmodule

// file: test/ssc_chk_sva.sv
// Port checker for the sleep control block.
// Assumes binding into ssc_sleep_ctrl; one clock domain.
`timescale 1ns/100ps
`include "ssc_defines.vh"
module ssc_chk (
  input wire                   ref_clk,
  input wire                   rstn,
  input wire                   sleep_request,
  input wire                   sleep_request_driven,
  input wire [1:0]             cmd,
  input wire [`SSC_DATA_W-1:0] rd_data,
  input wire                   rd_data_oe,
  input wire                   asleep,
  input wire                   recovering,
  input wire                   write_refused
);
  // Floating pin counts as low
  wire z = sleep_request & sleep_request_driven;
  wire rd = cmd == `SSC_CMD_READ;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_ENTRY: assert property ($rose(z) && !asleep && !recovering
    |-> !asleep[*4] ##1 asleep) else $error("sleep entry late");
  AST_HOLD: assert property (z ##1 (z && asleep) |=> asleep)
    else $error("woke early");
  AST_WAKE: assert property ($fell(z) && asleep ##1 !z[*2] |-> recovering
    ##1 !recovering && !asleep) else $error("recovery wrong");
  // Even a read taken on the entry edge must not show
  AST_FLOAT: assert property (asleep |-> !rd_data_oe)
    else $error("outputs driven asleep");
  AST_NOREAD: assert property (asleep && rd |=> !rd_data_oe)
    else $error("read served asleep");
  AST_KEEP: assert property (asleep |=> $stable(rd_data))
    else $error("data moved asleep");
  AST_UNDRV: assert property (!sleep_request_driven[*8] |-> !asleep)
    else $error("floating pin slept");
  AST_READ: assert property (!asleep && rd ##1 !asleep |-> rd_data_oe)
    else $error("read lost");
  cover property ($rose(asleep));
  cover property (write_refused);
  cover property ($fell(recovering));
endmodule
bind ssc_sleep_ctrl ssc_chk u_ssc_chk (
  .ref_clk              (ref_clk),
  .rstn                 (rstn),
  .sleep_request        (sleep_request),
  .sleep_request_driven (sleep_request_driven),
  .cmd                  (cmd),
  .rd_data              (rd_data),
  .rd_data_oe           (rd_data_oe),
  .asleep               (asleep),
  .recovering           (recovering),
  .write_refused        (write_refused)
);

// file: test/ssc_ctrl_model.sv
// Memory controller model driving the sleep block's pins.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
`include "ssc_defines.vh"
module ssc_ctrl_model (
  input wire                   ref_clk,
  output reg                   sleep_request,
  output reg                   sleep_request_driven,
  output reg [1:0]             cmd,
  output reg [`SSC_ADDR_W-1:0] addr,
  output reg [`SSC_DATA_W-1:0] wr_data
);
  initial begin
    sleep_request = 1'h0;
    sleep_request_driven = 1'h1;
    cmd = `SSC_CMD_NOP;
    addr = 4'h0;
    wr_data = 36'h0;
  end
  task op(input [1:0] c, input [3:0] a, input [35:0] d);
    @(posedge ref_clk);
    cmd <= c;
    addr <= a;
    // Bus not held outside writes
    wr_data <= (c == `SSC_CMD_WRITE) ? d : ~wr_data;
  endtask
  // Undriven pin toggles; no pull-down modelled here
  task sleep_pin(input l, input drv);
    @(posedge ref_clk);
    sleep_request <= drv ? l : ~sleep_request;
    sleep_request_driven <= drv;
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the sleep control block.
// Assumes the controller model drives every design input except ref_clk and rstn.
`timescale 1ns/100ps
`include "ssc_defines.vh"
module tb_top;
  reg         ref_clk = 1'h0;
  reg         rstn = 1'h0;
  wire        zq, zd, oe, slp, rec, wref;
  wire [1:0]  cmd;
  wire [3:0]  addr;
  wire [35:0] wd, rd;
  integer     n_mismatch = 0;
  integer     samples_checked = 0;
  always #20 ref_clk = ~ref_clk;
  ssc_ctrl_model u_ssc_ctrl_model (.ref_clk(ref_clk), .sleep_request(zq),
    .sleep_request_driven(zd), .cmd(cmd), .addr(addr), .wr_data(wd));
  ssc_sleep_ctrl u_ssc_sleep_ctrl (.ref_clk(ref_clk), .rstn(rstn), .sleep_request(zq),
    .sleep_request_driven(zd), .cmd(cmd), .addr(addr), .wr_data(wd), .rd_data(rd),
    .rd_data_oe(oe), .asleep(slp), .recovering(rec), .write_refused(wref));
  task check(input [63:0] nm, input [35:0] s, input [35:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task rd_chk(input [3:0] a, input [35:0] e);
    u_ssc_ctrl_model.op(`SSC_CMD_READ, a, 0);
    u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    #1 check("oe", oe, 1);
    check("rd", rd, e);
  endtask
  task t_sleep;
    u_ssc_ctrl_model.op(`SSC_CMD_WRITE, 5, 36'h9_a5c3_1e7b);
    u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    u_ssc_ctrl_model.sleep_pin(1, 1);
    repeat (3) u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    #1 check("early", slp, 0);
    u_ssc_ctrl_model.op(`SSC_CMD_READ, 5, 0);
    #1 check("asleep", slp, 1);
    u_ssc_ctrl_model.op(`SSC_CMD_WRITE, 5, 36'h0_1111_2222);
    #1 check("oe_off", oe, 0);
    u_ssc_ctrl_model.sleep_pin(0, 1);
    u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    u_ssc_ctrl_model.op(`SSC_CMD_WRITE, 5, 36'h0_3333_4444);
    #1 check("refuse", {rec, wref}, 2'h3);
    u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    #1 check("awake", {slp, rec}, 2'h0);
    rd_chk(5, 36'h9_a5c3_1e7b);
    $display("test sleep done");
  endtask
  task t_float;
    u_ssc_ctrl_model.sleep_pin(1, 0);
    repeat (6) u_ssc_ctrl_model.op(`SSC_CMD_NOP, 0, 0);
    #1 check("float", slp, 0);
    u_ssc_ctrl_model.op(`SSC_CMD_WRITE, 15, 36'hf_0f0f_0f0f);
    rd_chk(15, 36'hf_0f0f_0f0f);
    u_ssc_ctrl_model.sleep_pin(0, 1);
    $display("test float done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    t_sleep;
    t_float;
    conclude;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
endmodule
